// [rtl/serial_port_status_and_irq.sv]
// Operation
// - overrun enable bit2 gates; clearing drops pending
// - tx enable bit1 passes tx service
// - rx enable bit0 passes rx service
// - overrun interrupt on own output line
// - tx and rx service ORed together
// - data read pops rx, write pushes tx
// - narrow frames formatted by software, returned formatted
// - busy while framing or tx non-empty
// - status bit3 shows rx fifo full
// - status bit2 shows rx fifo non-empty
// - status bit1 shows tx fifo has room
// - status bit0 shows tx fifo empty
// - prescale bits 7:0, bit0 reads zero
// - ident register shows three interrupt states
// - any ident write clears overrun interrupt
// - separate tx and rx fifos, 8x16
`timescale 1ns/1ps
module serial_port_status_and_irq
  import serial_port_pkg::*;
#(
  parameter int FIFO_WORDS = serial_port_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               reset,
  // peripheral bus slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [31:0]                        paddr,
  input  wire logic [serial_port_pkg::DATA_W-1:0] pwdata,
  output logic      [serial_port_pkg::DATA_W-1:0] prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // serial link
  input  wire serial_port_pkg::link_in_t          link_pins,
  output logic                                    txd,
  output logic                                    txd_oe,
  // interrupt lines
  output logic                                    overrun_irq,
  output logic                                    combined_fifo_irq
);

  import serial_port_pkg::*;

  // ==========================================================
  // declarations
  irq_enables_t              irq_en;
  logic [PRESCALE_W-1:1]     prescale_hi;
  logic                      overrun_irq_status;
  logic                      tx_irq_status;
  logic                      rx_irq_status;
  logic                      busy_flag;
  logic                      rx_fifo_full;
  logic                      rx_fifo_not_empty;
  logic                      tx_fifo_not_full;
  logic                      tx_fifo_empty;

  logic                      setup_phase;
  logic                      access_done;
  logic                      wr_done;
  logic                      rd_done;
  logic                      addr_hit;
  logic [DATA_W-1:0]         next_prdata;

  logic                      tx_push;
  logic                      tx_in_ready;
  logic                      tx_out_valid;
  logic                      tx_pop;
  logic [DATA_W-1:0]         tx_head;
  logic [CNT_W-1:0]          tx_level;

  logic                      rx_push;
  logic                      rx_in_ready;
  logic                      rx_out_valid;
  logic                      rx_pop;
  logic [DATA_W-1:0]         rx_head;
  logic [CNT_W-1:0]          rx_level;

  link_events_t              ev;
  logic                      frame_active;
  logic [BIT_CNT_W-1:0]      bit_cnt;
  logic [DATA_W-1:0]         rx_shift;
  logic [DATA_W-1:0]         tx_shift;
  logic                      frame_done;
  logic [DATA_W-1:0]         frame_word;

  logic                      overrun_set;
  logic                      overrun_clear;

  // ==========================================================
  // bus decode
  // pready rises one cycle after setup, so every access has one wait-free access phase
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done     = access_done && pwrite;
  assign rd_done     = access_done && !pwrite;

  always_comb begin
    case (paddr)
      ADDR_CONTROL_IRQ_EN,
      ADDR_FIFO_DATA,
      ADDR_PORT_STATUS,
      ADDR_CLOCK_PRESCALE,
      ADDR_IRQ_IDENT:        addr_hit = 1'b1;
      default:               addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !addr_hit;
    end
  end

  // ==========================================================
  // read data, captured in the setup cycle
  always_comb begin
    next_prdata = DATA_ZERO;
    case (paddr)
      ADDR_CONTROL_IRQ_EN: begin
        next_prdata[POS_OVERRUN_EN] = irq_en.overrun_en;
        next_prdata[POS_TX_EN]      = irq_en.tx_en;
        next_prdata[POS_RX_EN]      = irq_en.rx_en;
      end
      ADDR_FIFO_DATA: begin
        // received word comes back as stored, right aligned
        next_prdata = rx_out_valid ? rx_head : DATA_ZERO;
      end
      ADDR_PORT_STATUS: begin
        next_prdata[POS_BUSY]      = busy_flag;
        next_prdata[POS_RX_FULL]   = rx_fifo_full;
        next_prdata[POS_RX_NEMPTY] = rx_fifo_not_empty;
        next_prdata[POS_TX_NFULL]  = tx_fifo_not_full;
        next_prdata[POS_TX_EMPTY]  = tx_fifo_empty;
      end
      ADDR_CLOCK_PRESCALE: begin
        next_prdata[PRESCALE_W-1:0] = {prescale_hi, 1'b0};
      end
      ADDR_IRQ_IDENT: begin
        next_prdata[POS_OVR_STAT] = overrun_irq_status;
        next_prdata[POS_TX_STAT]  = tx_irq_status;
        next_prdata[POS_RX_STAT]  = rx_irq_status;
      end
      default: begin
        next_prdata = DATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= DATA_ZERO;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_en <= irq_enables_t'(IRQ_EN_RESET);
    end else if (wr_done && paddr == ADDR_CONTROL_IRQ_EN) begin
      irq_en.overrun_en <= pwdata[POS_OVERRUN_EN];
      irq_en.tx_en      <= pwdata[POS_TX_EN];
      irq_en.rx_en      <= pwdata[POS_RX_EN];
    end
  end

  // an odd divisor is stored without its low bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prescale_hi <= PRESCALE_RESET[PRESCALE_W-1:1];
    end else if (wr_done && paddr == ADDR_CLOCK_PRESCALE) begin
      prescale_hi <= pwdata[PRESCALE_W-1:1];
    end
  end

  // ==========================================================
  // fifos
  // a write while the tx fifo is full is dropped; software checks room first
  assign tx_push = wr_done && (paddr == ADDR_FIFO_DATA);
  assign rx_pop  = rd_done && (paddr == ADDR_FIFO_DATA);

  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_WORDS),
    .CNT_W (CNT_W)
  ) u_tx_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (pwdata),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_head),
    .level     (tx_level)
  );

  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_WORDS),
    .CNT_W (CNT_W)
  ) u_rx_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (frame_word),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_head),
    .level     (rx_level)
  );

  // ==========================================================
  // status flags
  assign rx_fifo_full      = !rx_in_ready;
  assign rx_fifo_not_empty = rx_out_valid;
  assign tx_fifo_not_full  = tx_in_ready;
  assign tx_fifo_empty     = !tx_out_valid;
  assign busy_flag         = frame_active || tx_out_valid;

  // ==========================================================
  // link sampling and frame shifter
  link_sampler u_sampler (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pins    (link_pins),
    .events  (ev)
  );

  // tx word is taken at frame start; an empty fifo sends zeros
  assign tx_pop     = ev.frame_start && tx_out_valid;
  assign frame_done = frame_active && ev.sclk_rise && (bit_cnt == LAST_BIT);
  assign frame_word = {rx_shift[DATA_W-2:0], ev.rxd};
  // a full rx fifo refuses the word, so it is discarded here
  assign rx_push    = frame_done;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_active <= 1'b0;
      bit_cnt      <= '0;
      rx_shift     <= DATA_ZERO;
    end else if (ev.frame_start) begin
      frame_active <= 1'b1;
      bit_cnt      <= '0;
    end else if (ev.frame_n) begin
      frame_active <= 1'b0;
    end else if (frame_active && ev.sclk_rise) begin
      rx_shift     <= frame_word;
      bit_cnt      <= bit_cnt + 1'b1;
      frame_active <= (bit_cnt != LAST_BIT);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_shift <= DATA_ZERO;
    end else if (ev.frame_start) begin
      tx_shift <= tx_out_valid ? tx_head : DATA_ZERO;
    end else if (frame_active && ev.sclk_fall && bit_cnt != '0) begin
      tx_shift <= {tx_shift[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      txd    <= 1'b0;
      txd_oe <= 1'b0;
    end else begin
      txd    <= tx_shift[DATA_W-1];
      txd_oe <= frame_active;
    end
  end

  // ==========================================================
  // interrupt sources
  assign overrun_set   = frame_done && rx_fifo_full;
  assign overrun_clear = (wr_done && paddr == ADDR_IRQ_IDENT)
                         || (wr_done && paddr == ADDR_CONTROL_IRQ_EN
                             && !pwdata[POS_OVERRUN_EN]);

  // a new overrun in the clearing cycle survives
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      overrun_irq_status <= 1'b0;
    end else if (overrun_set) begin
      overrun_irq_status <= 1'b1;
    end else if (overrun_clear) begin
      overrun_irq_status <= 1'b0;
    end
  end

  // fifo service requests are levels that follow the fill state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_irq_status <= 1'b0;
      rx_irq_status <= 1'b0;
    end else begin
      tx_irq_status <= (tx_level <= HALF_LEVEL);
      rx_irq_status <= (rx_level <= HALF_LEVEL);
    end
  end

  // ==========================================================
  // interrupt outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      overrun_irq       <= 1'b0;
      combined_fifo_irq <= 1'b0;
    end else begin
      overrun_irq       <= overrun_irq_status && irq_en.overrun_en;
      combined_fifo_irq <= (tx_irq_status && irq_en.tx_en)
                           || (rx_irq_status && irq_en.rx_en);
    end
  end

endmodule

// [rtl/serial_port_pkg.sv]
package serial_port_pkg;

  // ==========================================================
  // data path
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W      = 4;
  localparam int BIT_CNT_W  = 4;
  localparam logic [CNT_W-1:0] HALF_LEVEL = 4'h4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hF;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [31:0] ADDR_CONTROL_IRQ_EN = 32'h4000_2204;
  localparam logic [31:0] ADDR_FIFO_DATA      = 32'h4000_2208;
  localparam logic [31:0] ADDR_PORT_STATUS    = 32'h4000_220C;
  localparam logic [31:0] ADDR_CLOCK_PRESCALE = 32'h4000_2210;
  localparam logic [31:0] ADDR_IRQ_IDENT      = 32'h4000_2214;

  // ==========================================================
  // field positions
  localparam int POS_OVERRUN_EN = 2;
  localparam int POS_TX_EN      = 1;
  localparam int POS_RX_EN      = 0;
  localparam int POS_BUSY       = 4;
  localparam int POS_RX_FULL    = 3;
  localparam int POS_RX_NEMPTY  = 2;
  localparam int POS_TX_NFULL   = 1;
  localparam int POS_TX_EMPTY   = 0;
  localparam int POS_OVR_STAT   = 2;
  localparam int POS_TX_STAT    = 1;
  localparam int POS_RX_STAT    = 0;
  localparam int PRESCALE_W     = 8;

  // ==========================================================
  // reset values
  localparam logic [2:0]            IRQ_EN_RESET   = 3'h0;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 8'h00;
  localparam logic [DATA_W-1:0]     DATA_ZERO      = 16'h0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic sclk;
    logic frame_n;
    logic rxd;
  } link_in_t;

  typedef struct packed {
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_n;
    logic rxd;
  } link_events_t;

  typedef struct packed {
    logic overrun_en;
    logic tx_en;
    logic rx_en;
  } irq_enables_t;

endpackage

// [rtl/word_fifo.sv]
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // fill level
  output logic      [CNT_W-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != CNT_W'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end

endmodule

// [rtl/link_sampler.sv]
`timescale 1ns/1ps
module link_sampler
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  // raw pins
  input  wire serial_port_pkg::link_in_t pins,
  // synchronised levels and edges
  output serial_port_pkg::link_events_t  events
);

  import serial_port_pkg::*;

  localparam int N = $bits(link_in_t);
  // reset to the idle pin levels so that no false edge follows reset
  localparam link_in_t IDLE_PINS = '{sclk: 1'b0, frame_n: 1'b1, rxd: 1'b0};

  logic [N-1:0] meta;
  logic [N-1:0] sync;
  logic [N-1:0] prev;
  link_in_t     now;
  link_in_t     old;

  // ==========================================================
  // two-stage synchroniser per pin
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          meta[i] <= IDLE_PINS[i];
          sync[i] <= IDLE_PINS[i];
          prev[i] <= IDLE_PINS[i];
        end else begin
          meta[i] <= pins[i];
          sync[i] <= meta[i];
          prev[i] <= sync[i];
        end
      end
    end
  endgenerate

  assign now = link_in_t'(sync);
  assign old = link_in_t'(prev);

  // edges compare the second stage with a third flop, never the first
  always_comb begin
    events.sclk_rise   = now.sclk && !old.sclk;
    events.sclk_fall   = !now.sclk && old.sclk;
    events.frame_start = !now.frame_n && old.frame_n;
    events.frame_n     = now.frame_n;
    events.rxd         = now.rxd;
  end

endmodule

// [testbench/serial_port_properties.sv]
`timescale 1ns/1ps
module serial_port_checker
  import serial_port_pkg::*;
#(
  parameter int FIFO_WORDS = 8
) (
  // clock and reset
  input wire logic                               ref_clk,
  input wire logic                               reset,
  // register bus
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [31:0]                        paddr,
  input wire logic [serial_port_pkg::DATA_W-1:0] pwdata,
  input wire logic [serial_port_pkg::DATA_W-1:0] prdata,
  input wire logic                               pready,
  input wire logic                               pslverr,
  // serial link
  input wire serial_port_pkg::link_in_t          link_pins,
  input wire logic                               txd,
  input wire logic                               txd_oe,
  // interrupt lines
  input wire logic                               overrun_irq,
  input wire logic                               combined_fifo_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // bus phases
  sequence s_setup(a, w);
    psel && !penable && pwrite == w && paddr == a;
  endsequence
  sequence s_wr(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  // ==========================================================
  // checks
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_unmapped_err: assert property (psel && !penable && !pwrite && paddr > ADDR_IRQ_IDENT
    |=> pslverr && prdata == 16'h0000)
    else $error("unmapped read not refused");
  a_reset_quiet: assert property ($fell(reset)
    |-> !pready && !overrun_irq && !combined_fifo_irq && !txd_oe)
    else $error("outputs active after reset");
  a_ident_write_clears: assert property (s_wr(ADDR_IRQ_IDENT) |-> ##[1:2] !overrun_irq)
    else $error("overrun line stays after clear");
  a_ovr_enable_off: assert property (
    s_wr(ADDR_CONTROL_IRQ_EN) ##0 !pwdata[POS_OVERRUN_EN] |-> ##[1:2] !overrun_irq)
    else $error("overrun line stays after disable");
  a_fifo_irq_off: assert property (s_wr(ADDR_CONTROL_IRQ_EN) ##0 pwdata[1:0] == 2'b00
    |-> ##[1:2] !combined_fifo_irq)
    else $error("fifo line stays after disable");
  a_prescale_even: assert property (s_setup(ADDR_CLOCK_PRESCALE, 1'b0)
    |=> prdata[0] == 1'b0 && prdata[15:8] == 8'h00)
    else $error("prescale reads odd");
  a_status_upper_zero: assert property (s_setup(ADDR_PORT_STATUS, 1'b0)
    |=> prdata[15:5] == 11'h000)
    else $error("status upper bits set");
  a_ident_upper_zero: assert property (s_setup(ADDR_IRQ_IDENT, 1'b0)
    |=> prdata[15:3] == 13'h0000)
    else $error("ident upper bits set");
endmodule

bind serial_port_status_and_irq serial_port_checker #(.FIFO_WORDS(FIFO_WORDS)) chk_u (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link_pins(link_pins), .txd(txd), .txd_oe(txd_oe), .overrun_irq(overrun_irq),
  .combined_fifo_irq(combined_fifo_irq)
);

// [testbench/serial_master_model.sv]
`timescale 1ns/1ps
module serial_master_model
  import serial_port_pkg::*;
(
  // serial lines
  output link_in_t  pins,
  input  wire logic txd
);
  // ==========================================================
  // idle: clock still, select high
  initial pins = 3'b010;

  // rxd moves mid low phase so it is stable around each sampled rise
  task automatic send_frame(input logic [15:0] tx_word, output logic [15:0] rx_word);
    // keep pin moves off the sampling clock edge
    #13;
    pins.frame_n = 1'b0;
    #300;
    for (int i = 15; i >= 0; i--) begin
      pins.rxd = tx_word[i];
      #150 pins.sclk = 1'b1;
      rx_word[i] = txd;
      #100 pins.sclk = 1'b0;
      #150;
    end
    pins.frame_n = 1'b1;
    // released line must not keep the last bit
    pins.rxd = ~pins.rxd;
    #400;
  endtask
endmodule

// [testbench/serial_port_status_and_irq_tb_top.sv]
`timescale 1ns/1ps
module serial_port_status_and_irq_tb_top;
  import serial_port_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0000_0000;
  logic [15:0] pwdata  = 16'h0000;
  logic [15:0] prdata;
  logic        pready, pslverr, txd, txd_oe, overrun_irq, combined_fifo_irq;
  link_in_t    link_pins;
  logic [16:0] exp_q[$];
  logic [15:0] txw[8], rxw[8], got, v;
  integer      seed = 32'hda4f64b3;
  int          fail_count = 0;
  int          n_tests = 0;

  serial_port_status_and_irq #(.FIFO_WORDS(8)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_pins(link_pins), .txd(txd), .txd_oe(txd_oe), .overrun_irq(overrun_irq),
    .combined_fifo_irq(combined_fifo_irq));
  serial_master_model master_u (.pins(link_pins), .txd(txd));

  initial forever #25 ref_clk = ~ref_clk;

  // ==========================================================
  // checking and closing
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (exp_q.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // register bus
  task automatic bus(input logic [31:0] a, input logic w, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    if (pready !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // gap lets status flops settle before the next read latches them
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [16:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 16'h0000);
  endtask
  task automatic irqs(input logic o, input logic c);
    repeat (3) @(posedge ref_clk);
    check({15'h0000, overrun_irq, combined_fifo_irq}, {15'h0000, o, c});
  endtask

  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("ERROR %0t: read with no expectation", $time);
      end else begin
        check({pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ADDR_PORT_STATUS, 17'h0_0003);
    rd(ADDR_IRQ_IDENT, 17'h0_0003);
    rd(32'h4000_2218, 17'h1_0000);
    wr(32'h4000_2218, 16'hFFFF);
    rd(ADDR_CONTROL_IRQ_EN, 17'h0_0000);
    for (int e = 0; e < 8; e++) begin
      wr(ADDR_CONTROL_IRQ_EN, 16'(e));
      rd(ADDR_CONTROL_IRQ_EN, 17'(e));
      irqs(1'b0, e[0] | e[1]);
    end
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 16'hFFFF : 16'($random(seed));
      wr(ADDR_CLOCK_PRESCALE, v);
      rd(ADDR_CLOCK_PRESCALE, {9'h000, v[7:1], 1'b0});
    end
    for (int i = 0; i < 8; i++) begin
      txw[i] = 16'($random(seed));
      rxw[i] = 16'($random(seed));
      wr(ADDR_FIFO_DATA, txw[i]);
      rd(ADDR_PORT_STATUS, {12'h000, 1'b1, 2'b00, i < 7, 1'b0});
      rd(ADDR_IRQ_IDENT, {15'h0000, i < 4, 1'b1});
    end
    wr(ADDR_FIFO_DATA, 16'hDEAD);
    rd(ADDR_PORT_STATUS, 17'h0_0010);
    for (int i = 0; i < 8; i++) begin
      master_u.send_frame(rxw[i], got);
      check({1'b0, got}, {1'b0, txw[i]});
    end
    repeat (4) @(posedge ref_clk);
    rd(ADDR_PORT_STATUS, 17'h0_000F);
    rd(ADDR_IRQ_IDENT, 17'h0_0002);
    wr(ADDR_CONTROL_IRQ_EN, 16'h0004);
    for (int r = 0; r < 2; r++) begin
      // busy and output enable are looked at while the frame runs
      fork
        master_u.send_frame(16'($random(seed)), got);
        begin
          repeat (40) @(posedge ref_clk);
          rd(ADDR_PORT_STATUS, 17'h0_001F);
          check({16'h0000, txd_oe}, 17'h0_0001);
        end
      join
      check({16'h0000, txd_oe}, 17'h0_0000);
      check({1'b0, got}, 17'h0_0000);
      irqs(1'b1, 1'b0);
      rd(ADDR_IRQ_IDENT, 17'h0_0006);
      if (r == 0) wr(ADDR_IRQ_IDENT, 16'($random(seed)));
      else wr(ADDR_CONTROL_IRQ_EN, 16'h0000);
      irqs(1'b0, 1'b0);
      rd(ADDR_IRQ_IDENT, 17'h0_0002);
    end
    for (int k = 0; k < 9; k++) begin
      rd(ADDR_FIFO_DATA, {1'b0, (k < 8) ? rxw[k] : 16'h0000});
      rd(ADDR_PORT_STATUS, {14'h0000, k < 7, 2'b11});
      rd(ADDR_IRQ_IDENT, {15'h0000, 1'b1, k > 2});
    end
    finish_test();
  end
endmodule
